// ==== hdl/sdrcb_core.sv ====
`timescale 1ns/100ps
module sdrcb_core (
  // Clock and reset
  input  wire logic                              I_CLK,
  input  wire logic                              I_ARST_N,
  // Command, address, mask and clock-gate pins
  input  wire sdrcb_pkg::sdrcb_cmd_t             I_CMD,
  input  wire sdrcb_pkg::sdrcb_addr_t            I_ADDR,
  input  wire sdrcb_pkg::sdrcb_mask_t            I_MASK,
  input  wire logic                              I_CKE,
  // Mode settings held by the mode register outside
  input  wire logic [1:0]                        I_CAS_LAT,
  input  wire logic [2:0]                        I_BURST_LEN,
  input  wire logic                              I_INTERLEAVE,
  // Array read port, data returns in the same cycle
  output logic                                   O_RD_REQ,
  output sdrcb_pkg::sdrcb_loc_t                  O_RD_LOC,
  input  wire logic [sdrcb_pkg::DATA_W-1:0]      I_RD_DATA,
  // Data pins, output side
  output logic      [sdrcb_pkg::DATA_W-1:0]      O_DQ,
  output logic      [1:0]                        O_DQ_OE,
  // Status
  output logic      [sdrcb_pkg::NUM_BANKS-1:0]   O_BANK_OPEN,
  output sdrcb_pkg::sdrcb_pwr_t                  O_PWR_STATE
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [sdrcb_pkg::NUM_BANKS-1:0]     bank_open_reg;
  logic [sdrcb_pkg::NUM_BANKS-1:0]     bank_open_next;
  logic [sdrcb_pkg::ROW_W-1:0]         row_reg [sdrcb_pkg::NUM_BANKS];
  logic [sdrcb_pkg::BANK_W-1:0]        rd_bank_reg;
  logic [sdrcb_pkg::ROW_W-1:0]         rd_row_reg;
  logic                                ap_reg;
  logic                                cke_q_reg;
  sdrcb_pkg::sdrcb_pwr_t               pwr_reg;
  sdrcb_pkg::sdrcb_pwr_t               pwr_next;
  logic [sdrcb_pkg::COL_W-1:0]         col;
  logic                                busy;
  logic                                done;

  wire [2:0]                      code    = {I_CMD.ras_n, I_CMD.cas_n, I_CMD.we_n};
  wire [sdrcb_pkg::BANK_W-1:0]    sel     = I_ADDR.array_select;
  wire                            flag    = I_ADDR.addr[sdrcb_pkg::PRE_FLAG_POS];
  wire                            live    = cke_q_reg && !I_CMD.cs_n;
  wire                            frozen  = !cke_q_reg;
  wire                            act_go  = live && code == sdrcb_pkg::CMD_ACT && !bank_open_reg[sel];
  wire                            pre_go  = live && code == sdrcb_pkg::CMD_PRE;
  wire                            rd_go   = live && code == sdrcb_pkg::CMD_RD && bank_open_reg[sel];
  wire                            wr_go   = live && code == sdrcb_pkg::CMD_WR && bank_open_reg[sel];
  wire                            ref_go  = live && code == sdrcb_pkg::CMD_REF;
  wire                            bst_go  = live && code == sdrcb_pkg::CMD_BST && busy;
  wire                            nop_cmd = I_CMD.cs_n || code == sdrcb_pkg::CMD_NOP;
  wire                            pre_hit = pre_go && (flag || sel == rd_bank_reg);
  wire                            stop    = bst_go || pre_hit || wr_go;
  wire                            ap_end  = done && ap_reg;

  always_comb begin
    bank_open_next = bank_open_reg;
    if (ap_end) begin
      bank_open_next[rd_bank_reg] = 1'b0;
    end
    if (act_go) begin
      bank_open_next[sel] = 1'b1;
    end
    if (pre_go) begin
      if (flag) begin
        bank_open_next = '0;
      end else begin
        bank_open_next[sel] = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bank_open_reg <= '0;
      rd_bank_reg   <= '0;
      rd_row_reg    <= '0;
      ap_reg        <= 1'b0;
    end else begin
      bank_open_reg <= bank_open_next;
      // read takes the bank and the auto precharge flag
      if (rd_go) begin
        rd_bank_reg <= sel;
        rd_row_reg  <= row_reg[sel];
        ap_reg      <= flag && I_BURST_LEN != sdrcb_pkg::BL_FULL;
      end
    end
  end

  // Row addresses need no reset; a bank is unusable until its activate writes one.
  always_ff @(posedge I_CLK) begin
    if (act_go) begin
      row_reg[sel] <= I_ADDR.addr;
    end
  end

  // ----------------------------------------------------------------
  // Burst column sequencing
  // ----------------------------------------------------------------
  // column stream
  sdrcb_burst u_burst (
    .clk          (I_CLK),
    .rst_n        (rst_n),
    .i_start      (rd_go),
    .i_start_col  (I_ADDR.addr[sdrcb_pkg::COL_W-1:0]),
    .i_bl         (I_BURST_LEN),
    .i_interleave (I_INTERLEAVE),
    .i_stop       (stop),
    .i_hold       (frozen),
    .o_col        (col),
    .o_valid      (busy),
    .o_done       (done)
  );

  // ----------------------------------------------------------------
  // Clock gate and power state
  // ----------------------------------------------------------------
  always_comb begin
    pwr_next = pwr_reg;
    // compare previous and current gate level
    if (cke_q_reg && !I_CKE) begin
      if (ref_go && !busy && bank_open_reg == '0) begin
        pwr_next = sdrcb_pkg::PWR_SELFREF;
      end else if (busy) begin
        pwr_next = sdrcb_pkg::PWR_SUSPEND;
      end else if (nop_cmd) begin
        pwr_next = sdrcb_pkg::PWR_DOWN;
      end else begin
        pwr_next = sdrcb_pkg::PWR_SUSPEND;
      end
    end else if (!cke_q_reg && I_CKE) begin
      pwr_next = sdrcb_pkg::PWR_NORMAL;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cke_q_reg <= 1'b1;
      pwr_reg   <= sdrcb_pkg::PWR_NORMAL;
    end else begin
      cke_q_reg <= I_CKE;
      pwr_reg   <= pwr_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data pipeline
  // ----------------------------------------------------------------
  // The array answers within the fetch cycle, so latency two loads the pins straight
  // from it and latency three adds one stage. A frozen clock holds every stage.
  sdrcb_pkg::sdrcb_mask_t          mask_q_reg;
  logic [sdrcb_pkg::DATA_W-1:0]    s1_data_reg;
  logic                            s1_v_reg;
  logic [sdrcb_pkg::DATA_W-1:0]    dq_reg;
  logic [1:0]                      oe_reg;

  wire                             cl2     = I_CAS_LAT == sdrcb_pkg::CL_2;
  wire                             word_v  = cl2 ? busy : s1_v_reg;
  wire [sdrcb_pkg::DATA_W-1:0]     word    = cl2 ? I_RD_DATA : s1_data_reg;
  wire [1:0]                       oe_next = {2{word_v && !wr_go}}
                                           & ~{mask_q_reg.high_byte_mask,
                                               mask_q_reg.low_byte_mask};

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_q_reg  <= '0;
      s1_data_reg <= '0;
      s1_v_reg    <= 1'b0;
      dq_reg      <= '0;
      oe_reg      <= 2'h0;
    end else if (!frozen) begin
      mask_q_reg  <= I_MASK;
      s1_data_reg <= I_RD_DATA;
      s1_v_reg    <= busy && !wr_go;
      dq_reg      <= word;
      oe_reg      <= oe_next;
    end
  end

  assign O_RD_REQ    = busy;
  assign O_RD_LOC    = {rd_bank_reg, rd_row_reg, col};
  assign O_DQ        = dq_reg;
  assign O_DQ_OE     = oe_reg;
  assign O_BANK_OPEN = bank_open_reg;
  assign O_PWR_STATE = pwr_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_deselect;
    @(posedge I_CLK) disable iff (!rst_n)
    (cke_q_reg && I_CMD.cs_n && !ap_end) |=> O_BANK_OPEN == $past(O_BANK_OPEN);
  endproperty
  a_deselect: assert property (p_deselect) else $error("Deselect changed bank state.");

  property p_pre_one;
    @(posedge I_CLK) disable iff (!rst_n)
    (pre_go && !flag) |=> !O_BANK_OPEN[$past(sel)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("Bank precharge left bank open.");

  property p_pre_all;
    @(posedge I_CLK) disable iff (!rst_n)
    (pre_go && flag) |=> O_BANK_OPEN == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("Close-all left a bank open.");

  property p_act;
    @(posedge I_CLK) disable iff (!rst_n)
    act_go |=> O_BANK_OPEN[$past(sel)] && row_reg[$past(sel)] == $past(I_ADDR.addr);
  endproperty
  a_act: assert property (p_act) else $error("Activate did not open the row.");

  property p_rd_col;
    @(posedge I_CLK) disable iff (!rst_n)
    rd_go |=> O_RD_REQ && O_RD_LOC.col == $past(I_ADDR.addr[sdrcb_pkg::COL_W-1:0]);
  endproperty
  a_rd_col: assert property (p_rd_col) else $error("Read fetched the wrong column.");

  property p_cl2;
    @(posedge I_CLK) disable iff (!rst_n)
    (rd_go && cl2 && I_CKE && I_MASK == '0) ##1 (!wr_go && cl2)
      |=> O_DQ_OE == 2'h3 && O_DQ == $past(I_RD_DATA);
  endproperty
  a_cl2: assert property (p_cl2) else $error("First word missed latency two.");

  property p_mask;
    @(posedge I_CLK) disable iff (!rst_n)
    (I_MASK.low_byte_mask && cke_q_reg) ##1 cke_q_reg |=> !O_DQ_OE[0];
  endproperty
  a_mask: assert property (p_mask) else $error("Low byte driven despite mask.");

  property p_wrap;
    @(posedge I_CLK) disable iff (!rst_n)
    (busy && col == sdrcb_pkg::COL_LAST && I_BURST_LEN == sdrcb_pkg::BL_FULL
     && !I_INTERLEAVE && cke_q_reg && nop_cmd) |=> busy && col == sdrcb_pkg::COL_FIRST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Full page did not wrap to zero.");

  property p_pre_stop;
    @(posedge I_CLK) disable iff (!rst_n)
    (pre_hit && !rd_go) |=> !O_RD_REQ;
  endproperty
  a_pre_stop: assert property (p_pre_stop) else $error("Precharge did not stop burst.");

  property p_suspend;
    @(posedge I_CLK) disable iff (!rst_n)
    (cke_q_reg && !I_CKE && busy && nop_cmd) |=> O_PWR_STATE == sdrcb_pkg::PWR_SUSPEND;
  endproperty
  a_suspend: assert property (p_suspend) else $error("Burst entered power-down.");

endmodule

// ==== hdl/sdrcb_pkg.sv ====
package sdrcb_pkg;

  localparam int NUM_BANKS    = 4;
  localparam int BANK_W       = 2;
  localparam int ROW_W        = 12;
  localparam int COL_W        = 8;
  localparam int DATA_W       = 16;
  localparam int PRE_FLAG_POS = 10;

  // Strobe codes as {row, column, write}.
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_BST = 3'h6;

  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [1:0] CL_2    = 2'h2;
  localparam logic [1:0] CL_3    = 2'h3;

  localparam logic [COL_W-1:0] COL_FIRST = 8'h00;
  localparam logic [COL_W-1:0] COL_LAST  = 8'hff;
  localparam logic [COL_W-1:0] COL_ONE   = 8'h01;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdrcb_cmd_t;

  typedef struct packed {
    logic [BANK_W-1:0] array_select;
    logic [ROW_W-1:0]  addr;
  } sdrcb_addr_t;

  typedef struct packed {
    logic high_byte_mask;
    logic low_byte_mask;
  } sdrcb_mask_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
  } sdrcb_loc_t;

  typedef enum logic [3:0] {
    PWR_NORMAL  = 4'h1,
    PWR_DOWN    = 4'h2,
    PWR_SUSPEND = 4'h4,
    PWR_SELFREF = 4'h8
  } sdrcb_pwr_t;

endpackage

// ==== hdl/sdrcb_burst.sv ====
`timescale 1ns/100ps
module sdrcb_burst (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Control
  input  wire logic                          i_start,
  input  wire logic [sdrcb_pkg::COL_W-1:0]   i_start_col,
  input  wire logic [2:0]                    i_bl,
  input  wire logic                          i_interleave,
  input  wire logic                          i_stop,
  input  wire logic                          i_hold,
  // Column stream
  output logic      [sdrcb_pkg::COL_W-1:0]   o_col,
  output logic                               o_valid,
  output logic                               o_done
);

  logic [sdrcb_pkg::COL_W-1:0] col_reg;
  logic [sdrcb_pkg::COL_W-1:0] start_reg;
  logic [sdrcb_pkg::COL_W-1:0] idx_reg;
  logic                        valid_reg;
  logic                        full_page;
  logic [sdrcb_pkg::COL_W-1:0] len;

  // Column of the idx-th word: wraps inside the burst, a full page wraps the whole row.
  function automatic logic [sdrcb_pkg::COL_W-1:0] col_of(
    input logic [sdrcb_pkg::COL_W-1:0] start,
    input logic [sdrcb_pkg::COL_W-1:0] idx,
    input logic [2:0]                  bl,
    input logic                        il
  );
    logic [sdrcb_pkg::COL_W-1:0] m;
    m = (bl == sdrcb_pkg::BL_FULL) ? sdrcb_pkg::COL_LAST
                                   : (sdrcb_pkg::COL_ONE << bl[1:0]) - sdrcb_pkg::COL_ONE;
    if (il && bl != sdrcb_pkg::BL_FULL) begin
      col_of = start ^ (idx & m);
    end else begin
      col_of = (start & ~m) | ((start + idx) & m);
    end
  endfunction

  assign full_page = (i_bl == sdrcb_pkg::BL_FULL);
  assign len       = sdrcb_pkg::COL_ONE << i_bl[1:0];
  assign o_col     = col_reg;
  assign o_valid   = valid_reg;
  assign o_done    = valid_reg && !i_hold && !i_start && !i_stop && !full_page && idx_reg == len;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_reg   <= sdrcb_pkg::COL_FIRST;
      start_reg <= sdrcb_pkg::COL_FIRST;
      idx_reg   <= sdrcb_pkg::COL_FIRST;
      valid_reg <= 1'b0;
    end else if (i_start) begin
      col_reg   <= i_start_col;
      start_reg <= i_start_col;
      idx_reg   <= sdrcb_pkg::COL_ONE;
      valid_reg <= 1'b1;
    end else if (valid_reg && !i_hold) begin
      if (i_stop || o_done) begin
        valid_reg <= 1'b0;
      end else begin
        col_reg <= col_of(start_reg, idx_reg, i_bl, i_interleave);
        idx_reg <= idx_reg + sdrcb_pkg::COL_ONE;
      end
    end
  end

endmodule

// ==== sim/sdrcb_ctl_model.sv ====
`timescale 1ns/100ps
module sdrcb_ctl_model #(
  parameter int T_RCD = 3,
  parameter int T_RC  = 8,
  parameter int T_RRD = 2,
  parameter int T_RAS = 5
) (
  // Clock
  input  wire logic              clk,
  // Pins toward the device
  output sdrcb_pkg::sdrcb_cmd_t  cmd,
  output sdrcb_pkg::sdrcb_addr_t addr,
  output sdrcb_pkg::sdrcb_mask_t mask,
  output logic                   cke
);
  // ----------------------------
  // Controller timing bookkeeping
  // ----------------------------
  int cyc      = 0;
  int last_act = -100;
  int act_t[4] = '{default: -100};

  initial begin
    cmd  = 4'hf;
    addr = '0;
    mask = '0;
    cke  = 1'b1;
  end

  always @(posedge clk) cyc <= cyc + 1;

  task automatic op(input logic [2:0] code, input logic [1:0] bank, input logic [11:0] a,
                    input logic [1:0] m = 2'h0, input logic ke = 1'b1, input logic sel = 1'b1);
    if (code == sdrcb_pkg::CMD_ACT)
      while (cyc - last_act < T_RRD || cyc - act_t[bank] < T_RC) @(posedge clk);
    if (code == sdrcb_pkg::CMD_RD || code == sdrcb_pkg::CMD_WR)
      while (cyc - act_t[bank] < T_RCD) @(posedge clk);
    if (code == sdrcb_pkg::CMD_PRE)
      for (int i = 0; i < 4; i++)
        while ((a[10] || i == bank) && cyc - act_t[i] < T_RAS) @(posedge clk);
    if (code == sdrcb_pkg::CMD_WR) begin
      @(posedge clk);
      mask <= 2'h3;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    cmd  <= {~sel, code};
    addr <= {bank, a};
    mask <= (code == sdrcb_pkg::CMD_WR) ? 2'h3 : m;
    cke  <= ke;
    if (code == sdrcb_pkg::CMD_ACT && sel) begin
      last_act    = cyc;
      act_t[bank] = cyc;
    end
    @(posedge clk);
    cmd  <= {1'b0, sdrcb_pkg::CMD_NOP};
    // Address is inverted once after the command so the device cannot lean on a stale value.
    addr <= ~addr;
    mask <= 2'h0;
  endtask
endmodule

// ==== sim/tb_sdrcb_core.sv ====
`timescale 1ns/100ps
module tb_sdrcb_core;
  localparam int MAX_CYCLES = 3000;

  logic                   I_CLK      = 1'b0;
  logic                   I_ARST_N   = 1'b0;
  logic [1:0]             cas_lat    = 2'h2;
  logic [2:0]             burst_len  = 3'h2;
  logic                   interleave = 1'b0;
  sdrcb_pkg::sdrcb_cmd_t  cmd;
  sdrcb_pkg::sdrcb_addr_t addr;
  sdrcb_pkg::sdrcb_mask_t mask;
  logic                   cke;
  logic                   rd_req;
  sdrcb_pkg::sdrcb_loc_t  rd_loc;
  logic [15:0]            rd_data;
  logic [15:0]            dq;
  logic [1:0]             dq_oe;
  logic [3:0]             bank_open;
  sdrcb_pkg::sdrcb_pwr_t  pwr;
  int                     mismatches = 0;
  int                     n_checks   = 0;
  int                     cycles     = 0;

  initial forever #10 I_CLK = ~I_CLK;

  // The array returns a word that names its own bank, the low six bits of its row, and its column.
  assign rd_data = {rd_loc.bank, rd_loc.row[5:0], rd_loc.col};

  sdrcb_ctl_model ctl (.clk(I_CLK), .cmd(cmd), .addr(addr), .mask(mask), .cke(cke));

  sdrcb_core dut (
    .I_CLK        (I_CLK),
    .I_ARST_N     (I_ARST_N),
    .I_CMD        (cmd),
    .I_ADDR       (addr),
    .I_MASK       (mask),
    .I_CKE        (cke),
    .I_CAS_LAT    (cas_lat),
    .I_BURST_LEN  (burst_len),
    .I_INTERLEAVE (interleave),
    .O_RD_REQ     (rd_req),
    .O_RD_LOC     (rd_loc),
    .I_RD_DATA    (rd_data),
    .O_DQ         (dq),
    .O_DQ_OE      (dq_oe),
    .O_BANK_OPEN  (bank_open),
    .O_PWR_STATE  (pwr)
  );

  // ----------------
  // Shared helpers
  // ----------------
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] ecol(input logic [7:0] s, input int i, input logic [2:0] bl,
                                      input logic il);
    logic [7:0] m;
    m = (bl == sdrcb_pkg::BL_FULL) ? 8'hff : 8'((1 << bl) - 1);
    if (il && bl != sdrcb_pkg::BL_FULL)
      return (s & ~m) | ((s ^ 8'(i)) & m);
    return (s & ~m) | ((s + 8'(i)) & m);
  endfunction

  task automatic set_mode(input logic [1:0] cl, input logic [2:0] bl, input logic il);
    @(posedge I_CLK);
    cas_lat    <= cl;
    burst_len  <= bl;
    interleave <= il;
  endtask

  task automatic settle();
    repeat (2) @(posedge I_CLK);
    @(negedge I_CLK);
  endtask

  // Samples n words one per cycle, optionally then the released pins.
  task automatic read_words(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c,
                            input int n, input int pre, input logic tail);
    repeat (pre) @(posedge I_CLK);
    for (int i = 0; i < n; i++) begin
      @(negedge I_CLK);
      chk_data(dq, {b, r[5:0], ecol(c, i, burst_len, interleave)});
      chk_flags({2'h0, dq_oe}, 4'h3);
    end
    if (tail) begin
      @(negedge I_CLK);
      chk_flags({2'h0, dq_oe}, 4'h0);
    end
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset();
    // Look between edges so that no output is read in the step that launches it.
    @(negedge I_CLK);
    chk_data(dq, 16'h0000);
    chk_flags(bank_open, 4'h0);
    chk_flags(pwr, sdrcb_pkg::PWR_NORMAL);
    chk_flags({2'h0, dq_oe}, 4'h0);
    chk_flags({3'h0, rd_req}, 4'h0);
    $display("test reset done");
  endtask

  task automatic t_banks();
    for (int b = 0; b < 4; b++)
      ctl.op(sdrcb_pkg::CMD_ACT, 2'(b), 12'h3c0);
    settle();
    chk_flags(bank_open, 4'hf);
    ctl.op(sdrcb_pkg::CMD_PRE, 2'h1, 12'h000, 2'h0, 1'b1, 1'b0);
    settle();
    chk_flags(bank_open, 4'hf);
    ctl.op(sdrcb_pkg::CMD_PRE, 2'h1, 12'h000);
    settle();
    chk_flags(bank_open, 4'hd);
    for (int k = 0; k < 2; k++) begin
      ctl.op(sdrcb_pkg::CMD_PRE, 2'h0, 12'h400);
      settle();
      chk_flags(bank_open, 4'h0);
    end
    $display("test banks done");
  endtask

  task automatic t_reads();
    logic [2:0] bl;
    logic [7:0] c;
    ctl.op(sdrcb_pkg::CMD_ACT, 2'h2, 12'h2c7);
    for (int k = 0; k < 5; k++) begin
      bl = (k < 4) ? 3'(k) : 3'h2;
      c  = 8'h03 + 8'(k);
      set_mode((k % 2 == 1) ? sdrcb_pkg::CL_3 : sdrcb_pkg::CL_2, bl, k == 4);
      ctl.op(sdrcb_pkg::CMD_RD, 2'h2, {4'h0, c});
      read_words(2'h2, 12'h2c7, c, 1 << bl, int'(cas_lat) - 1, 1'b1);
    end
    set_mode(sdrcb_pkg::CL_2, 3'h1, 1'b0);
    ctl.op(sdrcb_pkg::CMD_RD, 2'h2, 12'h409);
    read_words(2'h2, 12'h2c7, 8'h09, 2, 1, 1'b1);
    settle();
    chk_flags(bank_open, 4'h0);
    $display("test reads done");
  endtask

  task automatic t_mask_intr();
    ctl.op(sdrcb_pkg::CMD_ACT, 2'h0, 12'h011);
    set_mode(sdrcb_pkg::CL_2, 3'h2, 1'b0);
    ctl.op(sdrcb_pkg::CMD_RD, 2'h0, 12'h020, 2'h2);
    @(posedge I_CLK);
    @(negedge I_CLK);
    chk_flags({2'h0, dq_oe}, 4'h1);
    @(negedge I_CLK);
    chk_flags({2'h0, dq_oe}, 4'h3);
    repeat (3) @(posedge I_CLK);
    set_mode(sdrcb_pkg::CL_3, 3'h2, 1'b0);
    ctl.op(sdrcb_pkg::CMD_RD, 2'h0, 12'h010);
    ctl.op(sdrcb_pkg::CMD_RD, 2'h0, 12'h040);
    read_words(2'h0, 12'h011, 8'h10, 2, 0, 1'b0);
    read_words(2'h0, 12'h011, 8'h40, 4, 0, 1'b1);
    ctl.op(sdrcb_pkg::CMD_PRE, 2'h0, 12'h400);
    $display("test mask and interrupt done");
  endtask

  task automatic t_stop();
    for (int k = 0; k < 4; k++) begin
      set_mode(sdrcb_pkg::CL_2, sdrcb_pkg::BL_FULL, 1'b0);
      ctl.op(sdrcb_pkg::CMD_ACT, 2'h3, 12'h5a5);
      ctl.op(sdrcb_pkg::CMD_RD, 2'h3, 12'h0fe);
      read_words(2'h3, 12'h5a5, 8'hfe, 4, 1, 1'b0);
      case (k)
        0: ctl.op(sdrcb_pkg::CMD_PRE, 2'h3, 12'h000);
        1: ctl.op(sdrcb_pkg::CMD_PRE, 2'h0, 12'h400);
        2: ctl.op(sdrcb_pkg::CMD_BST, 2'h0, 12'h000);
        default: ctl.op(sdrcb_pkg::CMD_WR, 2'h3, 12'h000);
      endcase
      repeat (3) @(posedge I_CLK);
      @(negedge I_CLK);
      chk_flags({2'h0, dq_oe}, 4'h0);
      chk_flags(bank_open, (k < 2) ? 4'h0 : 4'h8);
      ctl.op(sdrcb_pkg::CMD_PRE, 2'h0, 12'h400);
    end
    $display("test stop done");
  endtask

  task automatic t_power();
    for (int k = 0; k < 2; k++) begin
      ctl.op(k ? sdrcb_pkg::CMD_REF : sdrcb_pkg::CMD_NOP, 2'h0, 12'h000, 2'h0, 1'b0);
      settle();
      chk_flags(pwr, k ? sdrcb_pkg::PWR_SELFREF : sdrcb_pkg::PWR_DOWN);
      ctl.op(sdrcb_pkg::CMD_NOP, 2'h0, 12'h000, 2'h0, 1'b1, 1'b0);
      settle();
      chk_flags(pwr, sdrcb_pkg::PWR_NORMAL);
    end
    set_mode(sdrcb_pkg::CL_2, sdrcb_pkg::BL_FULL, 1'b0);
    ctl.op(sdrcb_pkg::CMD_ACT, 2'h1, 12'h0c3);
    ctl.op(sdrcb_pkg::CMD_RD, 2'h1, 12'h000);
    read_words(2'h1, 12'h0c3, 8'h00, 2, 1, 1'b0);
    ctl.op(sdrcb_pkg::CMD_NOP, 2'h0, 12'h000, 2'h0, 1'b0);
    settle();
    chk_flags(pwr, sdrcb_pkg::PWR_SUSPEND);
    chk_data(dq, 16'h4303);
    ctl.op(sdrcb_pkg::CMD_NOP, 2'h0, 12'h000, 2'h0, 1'b1, 1'b0);
    settle();
    chk_flags(pwr, sdrcb_pkg::PWR_NORMAL);
    ctl.op(sdrcb_pkg::CMD_BST, 2'h0, 12'h000);
    ctl.op(sdrcb_pkg::CMD_PRE, 2'h0, 12'h400);
    $display("test power done");
  endtask

  // A hung handshake must not stall the run forever.
  always @(posedge I_CLK) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    repeat (3) @(posedge I_CLK);
    t_reset();
    t_banks();
    t_reads();
    t_mask_intr();
    t_stop();
    t_power();
    complete_run();
  end
endmodule
